// ### src/rpmc_top.sv
`timescale 1ns/1ps
// What this block does
// - Hold reset until supply reaches operating level
// - Reset when digital supply drops too low
// - External reset pin low resets, high idles
// - Unserviced watchdog timeout resets the device
// - Software request causes full device reset
// - Protection fault gives interrupt or reset
// - Hibernate freezes state, wakeup leaves through reset
// - Pin, supply and power-on resets act asynchronously, internal sources on the clock
// - Cause record survives reset for software
// - Basic watchdog: 16-bit counter on slow oscillator
// - Each multi watchdog: two 16-bit, one 32-bit
// - Every 16-bit watchdog counter can reset device
// - Every watchdog counter interrupts on match
// - Basic watchdog wakes in all low modes
// - Multi watchdogs on selectable clock, not hibernate
// - CPU sleep halts code, system stays running
// - CPU deep sleep halts, requests system deep sleep
// - System deep sleep only after both CPUs
// - Reduced voltage mode restricts clock speeds
module rpmc_top
    import rpmc_pkg::*;
(
    input  wire logic                                  sys_clk_in,
    input  wire logic                                  resetn_in,
    input  wire logic                                  supply_ok_in,
    input  wire logic                                  supply_drop_detector_in,
    input  wire logic                                  external_reset_pin_n_in,
    input  wire logic                                  sw_reset_req_in,
    input  wire logic                                  prot_fault_in,
    input  wire logic                                  fault_reset_en_in,
    input  wire logic [CAUSE_W-1:0]                    cause_clear_in,
    input  wire logic                                  low_speed_osc_tick_in,
    input  wire logic                                  watch_crystal_osc_tick_in,
    input  wire logic                                  low_freq_clock_sel_in,
    input  wire logic                                  bwd_enable_in,
    input  wire logic                                  bwd_service_in,
    input  wire logic [BWD_W-1:0]                      bwd_match_in,
    input  wire logic [1:0]                            bwd_mode_in,
    input  wire logic [MCW_NUM-1:0]                    mcw_enable_in,
    input  wire logic [MCW_NUM*MCW_CNT-1:0]            mcw_service_in,
    input  wire logic [MCW_NUM*2-1:0][MCW_NARROW_W-1:0] mcw_narrow_match_in,
    input  wire logic [MCW_NUM-1:0][MCW_WIDE_W-1:0]    mcw_wide_match_in,
    input  wire logic [MCW_NUM*MCW_CNT-1:0][1:0]       mcw_mode_in,
    input  wire logic [1:0]                            cpu_sleep_req_in,
    input  wire logic [1:0]                            cpu_deep_sleep_req_in,
    input  wire logic                                  hibernate_req_in,
    input  wire logic                                  reduced_voltage_sel_in,
    input  wire logic                                  wake_int_in,
    input  wire logic                                  hib_wake_in,
    output logic                                       sys_reset_n_out,
    output logic [CAUSE_W-1:0]                         reset_cause_out,
    output logic                                       fault_int_out,
    output logic                                       bwd_int_out,
    output logic [MCW_NUM*MCW_CNT-1:0]                 mcw_int_out,
    output logic [1:0]                                 cpu_halt_out,
    output logic [1:0]                                 sys_deep_req_out,
    output logic [1:0]                                 sys_mode_out,
    output logic                                       hs_clk_en_out,
    output logic                                       io_freeze_out,
    output logic                                       reduced_voltage_mode_out,
    output logic                                       clk_speed_limit_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset combination

    logic                  hard_rst_n;
    logic                  core_rst_n;
    logic                  soft_req;
    logic                  hib_wake_evt;
    logic                  bwd_rst;
    logic [MCW_NUM*MCW_CNT-1:0] mcw_rst;
    logic                  bwd_int;
    logic                  wake_any;
    logic [RST_HOLD_W-1:0] hold_q;
    logic [1:0]            rel_q;
    logic [CAUSE_W-1:0]    cause_q;
    logic [CAUSE_W-1:0]    cause_set;
    rpmc_sys_mode_t        mode_q;
    rpmc_sys_mode_t        mode_d;
    logic [1:0]            cpu_ds_q;
    logic [1:0]            cpu_halt_q;
    logic                  fault_int_q;
    logic                  freeze_q;
    logic                  hs_en_q;
    logic                  reduced_q;

    // Pin, supply and power-on sources clear the reset flops without a clock
    assign hard_rst_n = resetn_in && supply_ok_in && !supply_drop_detector_in
                        && external_reset_pin_n_in;

    assign hib_wake_evt = (mode_q == RPMC_SYS_HIB) && (hib_wake_in || bwd_int);

    assign soft_req = bwd_rst || (|mcw_rst) || sw_reset_req_in
                      || (prot_fault_in && fault_reset_en_in) || hib_wake_evt;

    // Stretch keeps a short internal request from giving a runt reset
    always_ff @(posedge sys_clk_in or negedge hard_rst_n) begin
        if (!hard_rst_n) begin
            hold_q <= RST_HOLD_RST;
        end else if (soft_req) begin
            hold_q <= RST_HOLD_CYC;
        end else if (hold_q != RST_HOLD_RST) begin
            hold_q <= hold_q - RST_HOLD_W'(1);
        end
    end

    // Assertion is immediate on hard sources, release is always clocked
    always_ff @(posedge sys_clk_in or negedge hard_rst_n) begin
        if (!hard_rst_n) begin
            rel_q <= 2'h0;
        end else begin
            rel_q <= {rel_q[0], !(soft_req || hold_q != RST_HOLD_RST)};
        end
    end

    assign core_rst_n      = rel_q[1];
    assign sys_reset_n_out = rel_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Cause record, cleared by the power-on reset and by cause_clear_in

    always_comb begin
        cause_set               = CAUSE_RST;
        cause_set[CAUSE_SUPPLY] = !supply_ok_in || supply_drop_detector_in;
        cause_set[CAUSE_PIN]    = !external_reset_pin_n_in;
        cause_set[CAUSE_BWD]    = bwd_rst;
        cause_set[CAUSE_MCW]    = |mcw_rst;
        cause_set[CAUSE_SW]     = sw_reset_req_in;
        cause_set[CAUSE_FAULT]  = prot_fault_in && fault_reset_en_in;
        cause_set[CAUSE_HIB]    = hib_wake_evt;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cause_q <= CAUSE_RST;
        end else begin
            cause_q <= (cause_q & ~cause_clear_in) | cause_set;
        end
    end

    assign reset_cause_out = cause_q;

    ////////////////////////////////////////////////////////////////////////////
    // Watchdogs

    logic [MCW_NUM*MCW_CNT-1:0] mcw_int;
    logic                        mcw_tick;
    logic                        mcw_run;

    // Wide counters interrupt only
    function automatic rpmc_wd_mode_t wide_mode(input logic [1:0] m);
        wide_mode = m[0] ? RPMC_WD_INT : RPMC_WD_OFF;
    endfunction

    assign mcw_tick = low_freq_clock_sel_in ? watch_crystal_osc_tick_in
                                            : low_speed_osc_tick_in;
    assign mcw_run  = (mode_q != RPMC_SYS_HIB);

    rpmc_wd_counter #(.W(BWD_W)) u_basic_watchdog (
        .sys_clk_in    (sys_clk_in),
        .rst_n_in      (core_rst_n),
        .tick_in       (low_speed_osc_tick_in),
        .enable_in     (bwd_enable_in),
        .service_in    (bwd_service_in),
        .match_in      (bwd_match_in),
        .mode_in       (rpmc_wd_mode_t'(bwd_mode_in)),
        .count_out     (),
        .int_out       (bwd_int),
        .reset_req_out (bwd_rst)
    );

    for (genvar i = 0; i < MCW_NUM; i++) begin : g_mcw
        for (genvar j = 0; j < 2; j++) begin : g_narrow
            rpmc_wd_counter #(.W(MCW_NARROW_W)) u_narrow (
                .sys_clk_in    (sys_clk_in),
                .rst_n_in      (core_rst_n),
                .tick_in       (mcw_tick),
                .enable_in     (mcw_enable_in[i] && mcw_run),
                .service_in    (mcw_service_in[i*MCW_CNT+j]),
                .match_in      (mcw_narrow_match_in[i*2+j]),
                .mode_in       (rpmc_wd_mode_t'(mcw_mode_in[i*MCW_CNT+j])),
                .count_out     (),
                .int_out       (mcw_int[i*MCW_CNT+j]),
                .reset_req_out (mcw_rst[i*MCW_CNT+j])
            );
        end
        rpmc_wd_counter #(.W(MCW_WIDE_W)) u_wide (
            .sys_clk_in    (sys_clk_in),
            .rst_n_in      (core_rst_n),
            .tick_in       (mcw_tick),
            .enable_in     (mcw_enable_in[i] && mcw_run),
            .service_in    (mcw_service_in[i*MCW_CNT+2]),
            .match_in      (mcw_wide_match_in[i]),
            .mode_in       (wide_mode(mcw_mode_in[i*MCW_CNT+2])),
            .count_out     (),
            .int_out       (mcw_int[i*MCW_CNT+2]),
            .reset_req_out (mcw_rst[i*MCW_CNT+2])
        );
    end

    assign bwd_int_out = bwd_int;
    assign mcw_int_out = mcw_int;
    assign wake_any    = wake_int_in || bwd_int || (|mcw_int);

    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            fault_int_q <= 1'b0;
        end else begin
            fault_int_q <= prot_fault_in && !fault_reset_en_in;
        end
    end

    assign fault_int_out = fault_int_q;

    ////////////////////////////////////////////////////////////////////////////
    // Power modes

    // Deep-sleep request of a CPU stands until a wakeup
    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            cpu_ds_q <= 2'h0;
        end else if (wake_any) begin
            cpu_ds_q <= 2'h0;
        end else if (mode_q == RPMC_SYS_RUN) begin
            cpu_ds_q <= cpu_ds_q | cpu_deep_sleep_req_in;
        end
    end

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            RPMC_SYS_RUN: begin
                if (hibernate_req_in) begin
                    mode_d = RPMC_SYS_HIB;
                end else if (&cpu_ds_q && !wake_any) begin
                    mode_d = RPMC_SYS_DEEP;
                end
            end
            RPMC_SYS_DEEP: begin
                if (wake_any) begin
                    mode_d = RPMC_SYS_RUN;
                end
            end
            // Hibernate is left only through the device reset
            RPMC_SYS_HIB: begin
                mode_d = RPMC_SYS_HIB;
            end
            default: begin
                mode_d = RPMC_SYS_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            mode_q <= RPMC_SYS_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            cpu_halt_q <= 2'h0;
        end else begin
            cpu_halt_q <= cpu_sleep_req_in | cpu_ds_q
                          | {2{mode_d != RPMC_SYS_RUN}};
        end
    end

    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            freeze_q <= 1'b0;
            hs_en_q  <= 1'b1;
        end else begin
            freeze_q <= (mode_d == RPMC_SYS_HIB);
            hs_en_q  <= (mode_d == RPMC_SYS_RUN);
        end
    end

    // Core voltage only changes while running, never across sleep
    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            reduced_q <= 1'b0;
        end else if (mode_q == RPMC_SYS_RUN) begin
            reduced_q <= reduced_voltage_sel_in;
        end
    end

    assign cpu_halt_out             = cpu_halt_q;
    assign sys_deep_req_out         = cpu_ds_q;
    assign sys_mode_out             = mode_q;
    assign hs_clk_en_out            = hs_en_q;
    assign io_freeze_out            = freeze_q;
    assign reduced_voltage_mode_out = reduced_q;
    assign clk_speed_limit_out      = reduced_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_soft_reset_asserts: assert property (
        @(posedge sys_clk_in) disable iff (!hard_rst_n)
        sw_reset_req_in && core_rst_n |-> ##2 !sys_reset_n_out
    ) else $error("software request did not reset the device");

    a_reset_held_stretch: assert property (
        @(posedge sys_clk_in) disable iff (!hard_rst_n)
        (hold_q != RST_HOLD_RST) |=> ##1 !sys_reset_n_out
    ) else $error("reset released while stretch still counting");

    a_deep_needs_both: assert property (
        @(posedge sys_clk_in) disable iff (!core_rst_n)
        (mode_q == RPMC_SYS_DEEP) && ($past(mode_q) == RPMC_SYS_RUN) |-> $past(&cpu_ds_q)
    ) else $error("deep sleep entered without both CPUs");

    a_hib_wake_reset: assert property (
        @(posedge sys_clk_in) disable iff (!hard_rst_n)
        core_rst_n && (mode_q == RPMC_SYS_HIB) && hib_wake_in |-> ##2 !sys_reset_n_out
    ) else $error("hibernate wakeup did not reset");

    a_hib_freeze_io: assert property (
        @(posedge sys_clk_in) disable iff (!core_rst_n)
        $rose(mode_q == RPMC_SYS_HIB) |-> io_freeze_out && !hs_clk_en_out
    ) else $error("hibernate without frozen I/O");

    a_fault_to_int: assert property (
        @(posedge sys_clk_in) disable iff (!core_rst_n)
        prot_fault_in && !fault_reset_en_in |=> fault_int_out && sys_reset_n_out
    ) else $error("fault without interrupt");

    a_cause_retained: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        cause_q[CAUSE_SW] && !cause_clear_in[CAUSE_SW] |=> cause_q[CAUSE_SW]
    ) else $error("cause bit lost");

    a_sleep_halts_cpu: assert property (
        @(posedge sys_clk_in) disable iff (!core_rst_n)
        cpu_sleep_req_in[0] |=> cpu_halt_out[0] && (mode_q != RPMC_SYS_DEEP || $past(&cpu_ds_q))
    ) else $error("CPU sleep did not halt");

    a_limit_follows_sel: assert property (
        @(posedge sys_clk_in) disable iff (!core_rst_n)
        mode_q == RPMC_SYS_RUN |=> clk_speed_limit_out == $past(reduced_voltage_sel_in)
    ) else $error("clock limit does not follow voltage choice");

    c_deep_sleep: cover property (
        @(posedge sys_clk_in) disable iff (!core_rst_n)
        $rose(mode_q == RPMC_SYS_DEEP) ##[1:50] (mode_q == RPMC_SYS_RUN)
    );

    c_hib_wake: cover property (
        @(posedge sys_clk_in) disable iff (!hard_rst_n)
        (mode_q == RPMC_SYS_HIB) && hib_wake_in
    );

    c_fault_reset: cover property (
        @(posedge sys_clk_in) disable iff (!hard_rst_n)
        prot_fault_in && fault_reset_en_in
    );

endmodule

// ### src/rpmc_pkg.sv
package rpmc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths and counts of the watchdogs
    localparam int BWD_W        = 16;
    localparam int MCW_NARROW_W = 16;
    localparam int MCW_WIDE_W   = 32;
    localparam int MCW_NUM      = 2;
    localparam int MCW_CNT      = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int RST_HOLD_NS   = 1000;
    localparam int RST_HOLD_W    = 4;
    localparam logic [RST_HOLD_W-1:0] RST_HOLD_CYC =
        RST_HOLD_W'((RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [RST_HOLD_W-1:0] RST_HOLD_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset cause record, bit positions
    localparam int CAUSE_W     = 7;
    localparam int CAUSE_SUPPLY = 0;
    localparam int CAUSE_PIN   = 1;
    localparam int CAUSE_BWD   = 2;
    localparam int CAUSE_MCW   = 3;
    localparam int CAUSE_SW    = 4;
    localparam int CAUSE_FAULT = 5;
    localparam int CAUSE_HIB   = 6;
    localparam logic [CAUSE_W-1:0] CAUSE_RST = 7'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Modes
    typedef enum logic [1:0] {
        RPMC_SYS_RUN  = 2'h0,
        RPMC_SYS_DEEP = 2'h1,
        RPMC_SYS_HIB  = 2'h3
    } rpmc_sys_mode_t;

    typedef enum logic [1:0] {
        RPMC_WD_OFF       = 2'h0,
        RPMC_WD_INT       = 2'h1,
        RPMC_WD_RESET     = 2'h2,
        RPMC_WD_INT_RESET = 2'h3
    } rpmc_wd_mode_t;

endpackage

// ### src/rpmc_wd_counter.sv
`timescale 1ns/1ps
module rpmc_wd_counter
    import rpmc_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic          sys_clk_in,
    input  wire logic          rst_n_in,
    input  wire logic          tick_in,
    input  wire logic          enable_in,
    input  wire logic          service_in,
    input  wire logic [W-1:0]  match_in,
    input  wire rpmc_wd_mode_t mode_in,
    output logic      [W-1:0]  count_out,
    output logic               int_out,
    output logic               reset_req_out
);

    logic [W-1:0] count_q;
    logic         armed_q;
    logic         int_q;
    logic         reset_q;
    logic         match_evt;

    assign match_evt = enable_in && tick_in && (count_q == match_in);

    ////////////////////////////////////////////////////////////////////////////
    // Free-running count, restarted by service or by a match
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_q <= '0;
        end else if (service_in) begin
            count_q <= '0;
        end else if (match_evt) begin
            count_q <= '0;
        end else if (enable_in && tick_in) begin
            count_q <= count_q + W'(1);
        end
    end

    // First match only warns when both interrupt and reset are enabled
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            armed_q <= 1'b0;
        end else if (service_in) begin
            armed_q <= 1'b0;
        end else if (match_evt) begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            int_q <= 1'b0;
        end else begin
            int_q <= match_evt && mode_in[0];
        end
    end

    // Held until the device reset clears this counter
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reset_q <= 1'b0;
        end else if (match_evt && (mode_in == RPMC_WD_RESET ||
                   (mode_in == RPMC_WD_INT_RESET && armed_q))) begin
            reset_q <= 1'b1;
        end
    end

    assign count_out     = count_q;
    assign int_out       = int_q;
    assign reset_req_out = reset_q;

    ////////////////////////////////////////////////////////////////////////////
    a_service_restart: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        service_in |=> (count_q == '0) && !armed_q
    ) else $error("service did not restart the watchdog count");

    a_match_raises_int: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        match_evt && (mode_in == RPMC_WD_INT) ##1 !match_evt |-> int_out ##1 !int_out
    ) else $error("match did not give a one-cycle interrupt");

    a_timeout_resets: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        match_evt && (mode_in == RPMC_WD_RESET) |=> reset_req_out [*2]
    ) else $error("timeout without reset request");

    c_timeout_reset: cover property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        $rose(reset_req_out)
    );

endmodule

// ### bench/rpmc_pin_model.sv
`timescale 1ns/1ps
module rpmc_pin_model (
    input  wire logic press_in,
    output logic      pin_n_out
);
    // Board button pulls low; a released pin rests at the pull-up level
    assign pin_n_out = press_in ? 1'h0 : 1'h1;
endmodule

// ### bench/reset_and_power_mode_control_tb.sv
`timescale 1ns/1ps
module reset_and_power_mode_control_tb;
    import rpmc_pkg::*;
    logic clk=0, rstn=0, sok=1, drop=0, press=0, swr=0, flt=0, fen=0, tk=0, wtk=0, lsel=0;
    logic ben=0, bsv=0, hib=0, rvs=0, wak=0, hwk=0, pin_n, rn, fi, bi, hs, frz, rvm, lim;
    logic [6:0] cclr=0, cause;
    logic [15:0] bm=0;
    logic [1:0] bmd=0, men=0, slp=0, dsl=0, halt, dreq, mode;
    logic [5:0] msv=0, mi;
    logic [3:0][15:0] mnm=0;
    logic [1:0][31:0] mwm=0;
    logic [5:0][1:0] mmd=0;
    logic [31:0] lf=32'hF01C;
    int bad_count=0, checks_done=0, n, m, i;
    rpmc_pin_model pm (.press_in(press), .pin_n_out(pin_n));
    rpmc_top uut (.sys_clk_in(clk), .resetn_in(rstn), .supply_ok_in(sok),
        .supply_drop_detector_in(drop), .external_reset_pin_n_in(pin_n),
        .sw_reset_req_in(swr), .prot_fault_in(flt), .fault_reset_en_in(fen),
        .cause_clear_in(cclr), .low_speed_osc_tick_in(tk), .watch_crystal_osc_tick_in(wtk),
        .low_freq_clock_sel_in(lsel), .bwd_enable_in(ben), .bwd_service_in(bsv),
        .bwd_match_in(bm), .bwd_mode_in(bmd), .mcw_enable_in(men), .mcw_service_in(msv),
        .mcw_narrow_match_in(mnm), .mcw_wide_match_in(mwm), .mcw_mode_in(mmd),
        .cpu_sleep_req_in(slp), .cpu_deep_sleep_req_in(dsl), .hibernate_req_in(hib),
        .reduced_voltage_sel_in(rvs), .wake_int_in(wak), .hib_wake_in(hwk),
        .sys_reset_n_out(rn), .reset_cause_out(cause), .fault_int_out(fi), .bwd_int_out(bi),
        .mcw_int_out(mi), .cpu_halt_out(halt), .sys_deep_req_out(dreq), .sys_mode_out(mode),
        .hs_clk_en_out(hs), .io_freeze_out(frz), .reduced_voltage_mode_out(rvm),
        .clk_speed_limit_out(lim));
    initial forever #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nx(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s exp %0h got %0h", nm, e, s);
        end
    endtask
    task end_of_test;
        $display("mismatches %0d checks %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task cy(input int k);
        repeat (k) @(posedge clk);
    endtask
    task sm;
        @(negedge clk);
    endtask
    task clr;
        cy(1); cclr <= 7'h7F;
        cy(1); cclr <= 7'h00;
    endtask
    // Waits for the release, then for three more edges before going on
    task rel;
        n = 0;
        while (rn !== 1'b1 && n < 40) begin sm; n++; end
        chk("rel", rn, 1'b1);
        cy(3);
    endtask
    task wlo;
        n = 0;
        while (rn !== 1'b0 && n < 20) begin sm; n++; end
        chk("rlo", rn, 1'b0);
    endtask
    initial begin #2000000; bad_count++; end_of_test; end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cy(6); sm;
        chk("hs_rst", hs, 1'b1);
        chk("cause0", cause, 7'h00);
        cy(6); rstn <= 1'b1; rel;
        // Supply drop, pin and supply not yet up each hold the device in reset
        for (i = 0; i < 3; i++) begin
            clr; lf = nx(lf);
            if (i == 1) press <= 1'b1; else if (i == 2) sok <= 1'b0; else drop <= 1'b1;
            #1 chk("hard", rn, 1'b0);
            cy(lf[1:0] + 1); press <= 1'b0; drop <= 1'b0; sok <= 1'b1; rel;
            chk("hcause", cause, (i == 1) ? 7'h02 : 7'h01);
        end
        clr; swr <= 1'b1; cy(1); swr <= 1'b0; sm;
        chk("sw_early", rn, 1'b1);
        cy(1); sm; chk("sw", rn, 1'b0);
        rel; chk("stretch", n >= 10, 1'b1);
        chk("swcause", cause, 7'h10);
        lf = nx(lf); m = lf[1:0] + 2;
        bm <= 16'(m); bmd <= 2'h1; ben <= 1'b1; mnm[0] <= 16'(m); mmd[0] <= 2'h1;
        men <= 2'h1; cy(1); tk <= 1'b1;
        // Interrupt pulse follows the edge after the one on which the count meets the match
        for (i = 1; i <= m + 2; i++) begin
            cy(1); sm; chk("bint", bi, i == m + 1);
            chk("mint", mi, {5'h00, i == m + 1});
        end
        cy(1); tk <= 1'b0; bsv <= 1'b1; msv <= 6'h3F; bmd <= 2'h2;
        clr; bsv <= 1'b0; msv <= 6'h00; tk <= 1'b1;
        wlo; cy(1); ben <= 1'b0; men <= 2'h0; tk <= 1'b0; rel;
        chk("wdcause", cause, 7'h04);
        // Warn-then-reset mode on a narrow counter, ticked from the crystal
        clr; mnm[3] <= 16'(m); mmd[4] <= 2'h3; men <= 2'h2; lsel <= 1'b1; wtk <= 1'b1;
        wlo; cy(1); men <= 2'h0; wtk <= 1'b0; rel;
        chk("mcwcause", cause, 7'h08);
        flt <= 1'b1; cy(1); flt <= 1'b0; n = 0;
        repeat (4) begin sm; n += (fi === 1'b1); end
        chk("fint", n, 1);
        chk("fnorst", rn, 1'b1);
        clr; fen <= 1'b1; flt <= 1'b1; cy(1); flt <= 1'b0; wlo; rel;
        chk("fcause", cause, 7'h20);
        slp <= 2'h3; cy(2); sm;
        chk("halt", halt, 2'h3);
        chk("run", mode, 2'h0);
        cy(1); slp <= 2'h0; dsl <= 2'h1; cy(4); sm;
        chk("onecpu", mode, 2'h0);
        cy(1); dsl <= 2'h3; cy(3); sm;
        chk("deep", mode, 2'h1);
        chk("dreq", dreq, 2'h3);
        chk("hsoff", hs, 1'b0);
        cy(1); dsl <= 2'h0; wak <= 1'b1; cy(1); wak <= 1'b0; repeat (4) sm;
        chk("wake", mode, 2'h0);
        cy(1); rvs <= 1'b1; cy(2); sm;
        chk("lim", lim, 1'b1);
        chk("rvm", rvm, 1'b1);
        clr; hib <= 1'b1; cy(3); sm;
        chk("frz", frz, 1'b1);
        chk("hib", mode, 2'h3);
        cy(1); hwk <= 1'b1; hib <= 1'b0; cy(1); hwk <= 1'b0; wlo; rel;
        chk("hcause", cause, 7'h40);
        end_of_test;
    end
endmodule
